// >>> rtl/hbc_pkg.sv
package hbc_pkg;
   // ************************************************
   // register offsets (byte addresses in config space)
   // ************************************************
   localparam logic [7:0] OFF_REVISION_ID  = 8'h08;
   localparam logic [7:0] OFF_PROG_IF      = 8'h09;
   localparam logic [7:0] OFF_SUBCLASS     = 8'h0a;
   localparam logic [7:0] OFF_BASE_CLASS   = 8'h0b;
   localparam logic [7:0] OFF_BURST_LIMIT  = 8'h0d;
   localparam logic [7:0] OFF_HEADER_KIND  = 8'h0e;
   localparam logic [7:0] OFF_WINDOW_BASE  = 8'h10;
   // ************************************************
   // fixed values and reset values
   // ************************************************
   localparam logic [7:0]  PROG_IF_VALUE     = 8'h00;
   localparam logic [7:0]  SUBCLASS_VALUE    = 8'h00;
   localparam logic [7:0]  BASE_CLASS_VALUE  = 8'h06;
   localparam logic [7:0]  HEADER_KIND_VALUE = 8'h00;
   localparam logic [31:0] WINDOW_BASE_RESET = 32'h0000_0000;
   localparam logic [7:0]  BURST_LIMIT_RESET = 8'h20;
   // ************************************************
   // window field layout and legacy video region
   // ************************************************
   localparam int          WIN_BASE_LSB      = 20;
   localparam int          WIN_BASE_W        = 12;
   localparam logic [19:0] VIDEO_LOW         = 20'ha0000;
   localparam logic [19:0] VIDEO_HIGH        = 20'hbffff;
   // zero value of the timer stands for this many cycles
   localparam logic [8:0]  BURST_ZERO_CYCLES = 9'h100;
   // ************************************************
   // burst tracker states
   // ************************************************
   typedef enum logic [0:0] {
      HBC_IDLE  = 1'b0,
      HBC_BURST = 1'b1
   } hbc_burst_state_t;
endpackage

// >>> rtl/hbc_cfg_if.sv
`timescale 1ns/1ps
interface hbc_cfg_if;
   logic [7:0]  burst_limit_timer;
   logic [11:0] window_base_high_bits;
   modport regs  (output burst_limit_timer, output window_base_high_bits);
   modport users (input burst_limit_timer, input window_base_high_bits);
endinterface

// >>> rtl/hbc_burst_limiter.sv
`timescale 1ns/1ps
module hbc_burst_limiter
   import hbc_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   rst,
   hbc_cfg_if.users    cfg,
   input  wire logic   burst_start,
   input  wire logic   burst_active,
   output logic        burst_expired
);
   hbc_burst_state_t state;
   hbc_burst_state_t next_state;
   logic [8:0]       count;
   logic [8:0]       next_count;
   logic [8:0]       limit;

   // ************************************************
   // cycle limit per burst
   // ************************************************
   // zero means 256
   assign limit = (cfg.burst_limit_timer == 8'h00) ? BURST_ZERO_CYCLES
                                                   : {1'b0, cfg.burst_limit_timer};

   always_comb
   begin
      next_state = state;
      next_count = count;
      case (state)
         HBC_IDLE:
         begin
            next_count = 9'h000;
            if (burst_start)
            begin
               next_state = HBC_BURST;
               next_count = 9'h001;
            end
         end
         HBC_BURST:
         begin
            if (!burst_active || burst_expired)
            begin
               next_state = HBC_IDLE;
               next_count = 9'h000;
            end
            else
               next_count = count + 9'h001;
         end
         default:
         begin
            next_state = HBC_IDLE;
            next_count = 9'h000;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state <= HBC_IDLE;
         count <= 9'h000;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign burst_expired = (state == HBC_BURST) && (count >= limit);

   burst_bound_a: assert property (@(posedge clock) disable iff (rst)
      (state == HBC_BURST) |-> (count <= limit))
      else $error("burst ran past the latency limit");
endmodule

// >>> rtl/hbc_window_decode.sv
`timescale 1ns/1ps
module hbc_window_decode
   import hbc_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   rst,
   hbc_cfg_if.users    cfg,
   input  wire logic   smm_mem_enable,
   input  wire logic   smm_active,
   input  wire logic   sysmgmt_mem_visible,
   input  wire logic   mem_req,
   input  wire logic [31:0] mem_addr,
   output logic        window_claim,
   output logic [31:0] video_addr
);
   logic window_open;
   logic in_window;
   logic next_claim;
   logic [31:0] next_video;

   assign window_open = (smm_mem_enable && smm_active) || sysmgmt_mem_visible;
   assign in_window = (mem_addr[31:WIN_BASE_LSB] == cfg.window_base_high_bits)
                      && (mem_addr[19:0] >= VIDEO_LOW)
                      && (mem_addr[19:0] <= VIDEO_HIGH);

   always_comb
   begin
      next_claim = mem_req && window_open && in_window;
      next_video = next_claim ? {12'h000, mem_addr[19:0]} : video_addr;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         window_claim <= 1'b0;
         video_addr   <= 32'h0000_0000;
      end
      else
      begin
         window_claim <= next_claim;
         video_addr   <= next_video;
      end
   end

   window_gate_a: assert property (@(posedge clock) disable iff (rst)
      (mem_req && !window_open) |=> !window_claim)
      else $error("window claimed while closed");

   shadow_addr_a: assert property (@(posedge clock) disable iff (rst)
      window_claim |-> (video_addr >= 32'h000a0000 && video_addr <= 32'h000bffff))
      else $error("shadow address outside legacy video range");
endmodule

// >>> rtl/hbc_host_bridge_config.sv
`timescale 1ns/1ps
module hbc_host_bridge_config
   import hbc_pkg::*;
#(
   parameter logic [7:0] REVISION_VALUE = 8'h01 // arbitrary value
)
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        cfg_read,
   input  wire logic        cfg_write,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   input  wire logic        smm_mem_enable,
   input  wire logic        smm_active,
   input  wire logic        sysmgmt_mem_visible,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             window_claim,
   output logic [31:0]      video_addr,
   input  wire logic        burst_start,
   input  wire logic        burst_active,
   output logic             burst_expired
);
   hbc_cfg_if cfg_bus ();

   logic [7:0]  burst_limit_timer;
   logic [7:0]  next_burst_limit_timer;
   logic [11:0] window_base_high_bits;
   logic [11:0] next_window_base_high_bits;
   logic [31:0] next_rdata;
   logic [31:0] dword_08;
   logic [31:0] dword_0c;
   logic [31:0] dword_10;
   logic [2:0]  smm_sync;
   logic        window_open_sync;
   logic [7:0]  revision_value;
   logic [7:0]  prog_interface_field;
   logic [7:0]  subclass_field;
   logic [7:0]  base_class_field;
   logic [7:0]  header_kind_field;
   logic [15:0] window_align_bits;
   logic        window_prefetch_flag;
   logic [1:0]  window_addr_type;
   logic        window_space_flag;
   logic        smm_en_s1, smm_en_s2, smm_act_s1, smm_act_s2, vis_s1, vis_s2;

   // ************************************************
   // config dword images
   // ************************************************
   // revision from parameter
   assign revision_value       = REVISION_VALUE;
   assign prog_interface_field = PROG_IF_VALUE;
   assign subclass_field       = SUBCLASS_VALUE;
   assign base_class_field     = BASE_CLASS_VALUE;
   assign header_kind_field    = HEADER_KIND_VALUE;
   assign window_align_bits    = 16'h0000;
   assign window_prefetch_flag = 1'b0;
   assign window_addr_type     = 2'b00;
   assign window_space_flag    = 1'b0;
   assign dword_08 = {base_class_field, subclass_field, prog_interface_field, revision_value};
   assign dword_0c = {8'h00, header_kind_field, burst_limit_timer, 8'h00};
   assign dword_10 = {window_base_high_bits, window_align_bits, window_prefetch_flag,
                      window_addr_type, window_space_flag};

   // ************************************************
   // register writes and reads
   // ************************************************
   always_comb
   begin
      next_burst_limit_timer     = burst_limit_timer;
      next_window_base_high_bits = window_base_high_bits;
      next_rdata                 = cfg_rdata;
      if (cfg_write && cfg_addr[7:2] == OFF_BURST_LIMIT[7:2] && cfg_byte_en[1])
         next_burst_limit_timer = cfg_wdata[15:8];
      if (cfg_write && cfg_addr[7:2] == OFF_WINDOW_BASE[7:2])
      begin
         if (cfg_byte_en[2])
            next_window_base_high_bits[3:0] = cfg_wdata[23:20];
         if (cfg_byte_en[3])
            next_window_base_high_bits[11:4] = cfg_wdata[31:24];
      end
      if (cfg_read)
      begin
         case (cfg_addr[7:2])
            OFF_REVISION_ID[7:2]: next_rdata = dword_08;
            OFF_BURST_LIMIT[7:2]: next_rdata = dword_0c;
            OFF_WINDOW_BASE[7:2]: next_rdata = dword_10;
            default:              next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         burst_limit_timer     <= BURST_LIMIT_RESET;
         window_base_high_bits <= WINDOW_BASE_RESET[31:20];
         cfg_rdata             <= 32'h0000_0000;
      end
      else
      begin
         burst_limit_timer     <= next_burst_limit_timer;
         window_base_high_bits <= next_window_base_high_bits;
         cfg_rdata             <= next_rdata;
      end
   end

   assign cfg_bus.burst_limit_timer     = burst_limit_timer;
   assign cfg_bus.window_base_high_bits = window_base_high_bits;

   // ************************************************
   // mode inputs from other logic, synchronised
   // ************************************************
   // sideband levels may come from a slower domain
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         smm_en_s1  <= 1'b0;
         smm_en_s2  <= 1'b0;
         smm_act_s1 <= 1'b0;
         smm_act_s2 <= 1'b0;
         vis_s1     <= 1'b0;
         vis_s2     <= 1'b0;
      end
      else
      begin
         smm_en_s1  <= smm_mem_enable;
         smm_en_s2  <= smm_en_s1;
         smm_act_s1 <= smm_active;
         smm_act_s2 <= smm_act_s1;
         vis_s1     <= sysmgmt_mem_visible;
         vis_s2     <= vis_s1;
      end
   end
   assign smm_sync = {smm_en_s2, smm_act_s2, vis_s2};
   // only for the checks: open window as the decoder sees it
   assign window_open_sync = (smm_sync[2] && smm_sync[1]) || smm_sync[0];

   // ************************************************
   // window decoder and burst limiter
   // ************************************************
   hbc_window_decode u_decode (
      .clock               (clock),
      .rst                 (rst),
      .cfg                 (cfg_bus.users),
      .smm_mem_enable      (smm_sync[2]),
      .smm_active          (smm_sync[1]),
      .sysmgmt_mem_visible (smm_sync[0]),
      .mem_req             (mem_req),
      .mem_addr            (mem_addr),
      .window_claim        (window_claim),
      .video_addr          (video_addr)
   );

   hbc_burst_limiter u_burst (
      .clock         (clock),
      .rst           (rst),
      .cfg           (cfg_bus.users),
      .burst_start   (burst_start),
      .burst_active  (burst_active),
      .burst_expired (burst_expired)
   );

   // ************************************************
   // checks
   // ************************************************
   // revision fixed
   rev_fixed_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h02) |=> (cfg_rdata[7:0] == REVISION_VALUE))
      else $error("revision byte changed");
   class_code_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h02) |=> (cfg_rdata[31:8] == 24'h060000))
      else $error("class bytes wrong");
   header_zero_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h03) |=> (cfg_rdata[23:16] == 8'h00))
      else $error("header type nonzero");
   timer_write_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_write && cfg_addr[7:2] == 6'h03 && cfg_byte_en[1])
      |=> (burst_limit_timer == $past(cfg_wdata[15:8])))
      else $error("latency timer not written");
   window_low_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h04) |=> (cfg_rdata[19:0] == 20'h00000))
      else $error("window low bits nonzero");
   window_write_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_write && cfg_addr[7:2] == 6'h04 && (&cfg_byte_en))
      |=> (window_base_high_bits == $past(cfg_wdata[31:20])))
      else $error("window base not written");

   // ************************************************
   // checks on fields, window and burst
   // ************************************************
   // interface byte zero
   prog_if_zero_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h02) |=> (cfg_rdata[15:8] == 8'h00))
      else $error("programming interface byte nonzero");

   subclass_zero_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h02) |=> (cfg_rdata[23:16] == 8'h00))
      else $error("subclass byte nonzero");

   timer_read_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h03) |=> (cfg_rdata[15:8] == $past(burst_limit_timer)))
      else $error("latency timer read wrong");

   timer_hold_a: assert property (@(posedge clock) disable iff (rst)
      !(cfg_write && cfg_addr[7:2] == 6'h03 && cfg_byte_en[1]) |=> $stable(burst_limit_timer))
      else $error("latency timer changed without write");

   base_read_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h04)
      |=> (cfg_rdata[31:20] == $past(window_base_high_bits)))
      else $error("window base read wrong");

   base_upper_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_write && cfg_addr[7:2] == 6'h04 && cfg_byte_en[3])
      |=> (window_base_high_bits[11:4] == $past(cfg_wdata[31:24])))
      else $error("window base upper lane not written");

   base_lower_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_write && cfg_addr[7:2] == 6'h04 && cfg_byte_en[2])
      |=> (window_base_high_bits[3:0] == $past(cfg_wdata[23:20])))
      else $error("window base low nibble not written");

   base_hold_a: assert property (@(posedge clock) disable iff (rst)
      !(cfg_write && cfg_addr[7:2] == 6'h04) |=> $stable(window_base_high_bits))
      else $error("window base changed without write");

   prefetch_zero_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h04) |=> (cfg_rdata[3] == 1'b0))
      else $error("window prefetch bit set");

   addr_type_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h04) |=> (cfg_rdata[2:1] == 2'b00))
      else $error("window address type nonzero");

   space_flag_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && cfg_addr[7:2] == 6'h04) |=> (cfg_rdata[0] == 1'b0))
      else $error("window space bit set");

   // unmapped dwords read zero
   unmapped_zero_a: assert property (@(posedge clock) disable iff (rst)
      (cfg_read && (cfg_addr[7:2] < 6'h02 || cfg_addr[7:2] > 6'h04))
      |=> (cfg_rdata == 32'h0000_0000))
      else $error("unmapped read nonzero");

   // read data stands until next read
   rdata_hold_a: assert property (@(posedge clock) disable iff (rst)
      !cfg_read |=> $stable(cfg_rdata))
      else $error("read data changed without read");

   claim_open_a: assert property (@(posedge clock) disable iff (rst)
      window_claim |-> $past(window_open_sync))
      else $error("claim while window closed");

   claim_request_a: assert property (@(posedge clock) disable iff (rst)
      window_claim |-> $past(mem_req))
      else $error("claim without request");

   claim_base_a: assert property (@(posedge clock) disable iff (rst)
      window_claim |-> ($past(mem_addr[31:20]) == $past(window_base_high_bits)))
      else $error("claim outside window base");

   claim_offset_a: assert property (@(posedge clock) disable iff (rst)
      window_claim |-> (video_addr[19:0] == $past(mem_addr[19:0])))
      else $error("shadow offset wrong");

   expire_pulse_a: assert property (@(posedge clock) disable iff (rst)
      burst_expired |=> !burst_expired)
      else $error("burst expiry held too long");
endmodule

// >>> test/hbc_host_model.sv
`timescale 1ns/1ps
module hbc_host_model
(
   input  wire logic        clock,
   output logic             cfg_read,
   output logic             cfg_write,
   output logic [7:0]       cfg_addr,
   output logic [3:0]       cfg_byte_en,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata
);
   // ****************************************
   // config requests, one at a time
   // ****************************************
   initial
   begin
      cfg_read = 1'b0;
      cfg_write = 1'b0;
      cfg_addr = 8'h00;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // released lines show the inverse, so stale values cannot pass
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clock);
      cfg_write = 1'b1;
      cfg_addr = a;
      cfg_byte_en = be;
      cfg_wdata = d;
      @(negedge clock);
      cfg_write = 1'b0;
      cfg_addr = ~a;
      cfg_byte_en = ~be;
      cfg_wdata = ~d;
   endtask
   task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge clock);
      cfg_read = 1'b1;
      cfg_addr = a;
      @(negedge clock);
      d = cfg_rdata;
      cfg_read = 1'b0;
      cfg_addr = ~a;
   endtask
   task automatic read_base(output logic [31:0] d);
      cfg_rd(8'h10, d);
   endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb
   import hbc_pkg::*;
;
   localparam logic [7:0] REV = 8'h4c; // arbitrary value
   logic        clock;
   logic        rst;
   logic        cfg_read;
   logic        cfg_write;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_byte_en;
   logic [31:0] cfg_wdata;
   logic [31:0] cfg_rdata;
   logic        smm_mem_enable;
   logic        smm_active;
   logic        sysmgmt_mem_visible;
   logic        mem_req;
   logic [31:0] mem_addr;
   logic        window_claim;
   logic [31:0] video_addr;
   logic        burst_start;
   logic        burst_active;
   logic        burst_expired;
   int          err_count;
   int          samples_checked;
   logic [31:0] d;
   logic [35:0] win_case [9];
   logic [7:0]  lim [3];

   hbc_host_bridge_config #(.REVISION_VALUE(REV)) uut
   (
      .clock(clock), .rst(rst), .cfg_read(cfg_read), .cfg_write(cfg_write),
      .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .smm_mem_enable(smm_mem_enable), .smm_active(smm_active),
      .sysmgmt_mem_visible(sysmgmt_mem_visible), .mem_req(mem_req), .mem_addr(mem_addr),
      .window_claim(window_claim), .video_addr(video_addr), .burst_start(burst_start),
      .burst_active(burst_active), .burst_expired(burst_expired)
   );
   hbc_host_model host
   (
      .clock(clock), .cfg_read(cfg_read), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
      .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata)
   );
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string m);
      chk32({31'h0, got}, {31'h0, exp}, m);
   endtask
   task automatic end_of_test();
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic mem_chk(input logic [31:0] a, input logic e);
      @(negedge clock);
      mem_req = 1'b1;
      mem_addr = a;
      @(negedge clock);
      mem_req = 1'b0;
      mem_addr = ~a;
      chk1(window_claim, e, "claim");
      if (e)
         chk32(video_addr, {12'h000, a[19:0]}, "video addr");
   endtask
   task automatic burst_chk(input logic [7:0] t);
      logic [31:0] n;
      host.cfg_wr(OFF_BURST_LIMIT, 4'h2, {16'h0000, t, 8'h00});
      @(negedge clock);
      burst_start = 1'b1;
      burst_active = 1'b1;
      @(negedge clock);
      burst_start = 1'b0;
      n = 32'h1;
      while (burst_expired !== 1'b1 && n < 32'd300)
      begin
         @(negedge clock);
         n++;
      end
      if (n >= 32'd300)
      begin
         err_count++;
         end_of_test();
      end
      chk32(n, (t == 8'h00) ? 32'd256 : {24'h0, t}, "burst length");
      @(negedge clock);
      burst_active = 1'b0;
      chk1(burst_expired, 1'b0, "expired stands one cycle");
   endtask
   // ****************************************
   // stimulus
   // ****************************************
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      err_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      {smm_mem_enable, smm_active, sysmgmt_mem_visible} = 3'b000;
      {mem_req, burst_start, burst_active} = 3'b000;
      mem_addr = 32'h0000_0000;
      win_case = '{{3'b001, 32'h800a_0000, 1'b1}, {3'b001, 32'h800b_ffff, 1'b1},
                   {3'b001, 32'h800c_0000, 1'b0}, {3'b001, 32'h8009_ffff, 1'b0},
                   {3'b001, 32'h900a_0000, 1'b0}, {3'b110, 32'h800a_5678, 1'b1},
                   {3'b010, 32'h800a_5678, 1'b0}, {3'b100, 32'h800a_5678, 1'b0},
                   {3'b000, 32'h800a_5678, 1'b0}};
      lim = '{8'h02, 8'h03, 8'h00};
      repeat (5) @(negedge clock);
      rst = 1'b0;
      host.cfg_rd(OFF_REVISION_ID, d);
      chk32(d, {BASE_CLASS_VALUE, SUBCLASS_VALUE, PROG_IF_VALUE, REV}, "id");
      host.cfg_rd(OFF_BURST_LIMIT, d);
      chk32(d, {8'h00, HEADER_KIND_VALUE, BURST_LIMIT_RESET, 8'h00}, "timer rst");
      host.cfg_rd(OFF_WINDOW_BASE, d);
      chk32(d, WINDOW_BASE_RESET, "base rst");
      // read-only bytes ignore an all-ones write
      host.cfg_wr(OFF_REVISION_ID, 4'hf, 32'hffff_ffff);
      host.cfg_rd(OFF_REVISION_ID, d);
      chk32(d, {8'h06, 8'h00, 8'h00, REV}, "ro id");
      host.cfg_wr(8'h0c, 4'hf, 32'hffff_ffff);
      host.cfg_rd(8'h0c, d);
      chk32(d, 32'h0000_ff00, "timer and header");
      host.cfg_wr(8'h0c, 4'hd, 32'h0000_0000);
      host.cfg_wr(8'h0c, 4'h2, 32'hffff_5aff);
      host.cfg_rd(8'h0c, d);
      chk32(d, 32'h0000_5a00, "timer lane");
      host.cfg_wr(OFF_WINDOW_BASE, 4'hf, 32'hffff_ffff);
      host.cfg_rd(OFF_WINDOW_BASE, d);
      chk32(d, 32'hfff0_0000, "base ro bits");
      host.cfg_wr(8'h14, 4'hf, 32'hffff_ffff);
      host.cfg_rd(8'h14, d);
      chk32(d, 32'h0000_0000, "unmapped");
      host.cfg_wr(OFF_WINDOW_BASE, 4'hf, 32'h8000_0000);
      host.read_base(d);
      chk32(d, 32'h8000_0000, "base");
      // ****************************************
      // window decode and burst limit
      // ****************************************
      for (int i = 0; i < 9; i++)
      begin
         @(negedge clock);
         {smm_mem_enable, smm_active, sysmgmt_mem_visible} = win_case[i][35:33];
         repeat (3) @(negedge clock);
         mem_chk(win_case[i][32:1], win_case[i][0]);
      end
      for (int i = 0; i < 3; i++)
         burst_chk(lim[i]);
      @(negedge clock);
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      host.cfg_rd(OFF_WINDOW_BASE, d);
      chk32(d, WINDOW_BASE_RESET, "base second rst");
      end_of_test();
   end
endmodule
